// ---- inc/psc_pkg.sv ----
/*
  Package for the slot capabilities register block: offsets, field positions,
  reset values and state encodings.
  Assumes a 32-bit APB register bus and a single core clock.
*/
package psc_pkg;
  // Byte address of the slot capabilities register.
  localparam logic [11:0] PSC_SLOT_CAP_ADDR = 12'h054;
  // Byte address of the control word (lock, slot-implemented flag, status).
  localparam logic [11:0] PSC_CTRL_ADDR = 12'h05C;
  // Field positions inside the slot capabilities word.
  localparam int PSC_ATTN_BTN_BIT = 0;
  localparam int PSC_PWR_CTRL_BIT = 1;
  localparam int PSC_LATCH_BIT = 2;
  localparam int PSC_ATTN_IND_BIT = 3;
  localparam int PSC_PWR_IND_BIT = 4;
  localparam int PSC_SURPRISE_BIT = 5;
  localparam int PSC_HOTPLUG_BIT = 6;
  localparam int PSC_LIMIT_LSB = 7;
  localparam int PSC_LIMIT_MSB = 14;
  localparam int PSC_SCALE_LSB = 15;
  localparam int PSC_SCALE_MSB = 16;
  localparam int PSC_INTERLOCK_BIT = 17;
  localparam int PSC_NO_CMD_DONE_BIT = 18;
  localparam int PSC_SLOTNUM_LSB = 19;
  localparam int PSC_SLOTNUM_MSB = 31;
  // Field positions inside the control word.
  localparam int PSC_CTRL_UNLOCK_BIT = 0;
  localparam int PSC_CTRL_SLOT_BIT = 1;
  localparam int PSC_CTRL_BUSY_BIT = 2;
  localparam int PSC_CTRL_LINK_BIT = 3;
  // Reset values.
  localparam logic [31:0] PSC_SLOT_CAP_RESET = 32'h0000_0000;
  localparam logic PSC_UNLOCK_RESET = 1'b0;
  localparam logic PSC_SLOT_RESET = 1'b0;
  // Power limit scale encodings.
  localparam logic [1:0] PSC_SCALE_X1 = 2'h0;
  localparam logic [1:0] PSC_SCALE_XP1 = 2'h1;
  localparam logic [1:0] PSC_SCALE_XP01 = 2'h2;
  localparam logic [1:0] PSC_SCALE_XP001 = 2'h3;
  // Message sender states.
  typedef enum logic [1:0] {
    PSC_MSG_IDLE = 2'b00,
    PSC_MSG_SEND = 2'b01,
    PSC_MSG_PEND = 2'b10
  } psc_msg_state_t;
endpackage

// ---- core/psc_msg_tx.sv ----
/*
  Power limit message sender: latches a request and presents the limit value
  and scale on a valid/ready pair until the message path accepts it.
  Assumes the message path holds msg_ready for as long as it wishes.
*/
`timescale 1ns/1ps
module psc_msg_tx
  import psc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [7:0] value,
  input wire logic [1:0] scale,
  input wire logic msg_ready,
  output logic msg_valid,
  output logic [7:0] msg_value,
  output logic [1:0] msg_scale,
  output logic busy
);
  typedef struct packed {
    psc_msg_state_t st;
    logic valid;
    logic [7:0] val;
    logic [1:0] scl;
  } psc_tx_t;

  psc_tx_t r;
  psc_tx_t next_r;

  // A request during a send is kept pending so the latest value is sent next.
  always_comb begin
    next_r = r;
    case (r.st)
      PSC_MSG_IDLE: begin
        if (req) begin
          next_r.st = PSC_MSG_SEND;
          next_r.valid = 1'b1;
          next_r.val = value;
          next_r.scl = scale;
        end
      end
      PSC_MSG_SEND: begin
        if (req) begin
          next_r.st = PSC_MSG_PEND;
        end
        if (msg_ready) begin
          next_r.valid = 1'b0;
          next_r.st = req ? PSC_MSG_PEND : PSC_MSG_IDLE;
        end
      end
      PSC_MSG_PEND: begin
        if (!r.valid) begin
          next_r.st = PSC_MSG_SEND;
          next_r.valid = 1'b1;
          next_r.val = value;
          next_r.scl = scale;
        end else if (msg_ready) begin
          next_r.valid = 1'b0;
        end
      end
      default: begin
        next_r.st = PSC_MSG_IDLE;
        next_r.valid = 1'b0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign msg_valid = r.valid;
  assign msg_value = r.val;
  assign msg_scale = r.scl;
  assign busy = (r.st != PSC_MSG_IDLE);
endmodule

// ---- core/psc_slot_cap.sv ----
/*
  Slot capabilities register of a switch port, reached over APB, with the
  slot power limit message trigger and a small control word.
  Assumes APB from a single master in the pclk domain and a link-active level
  that is synchronous to pclk.
*/
// Functional notes
// - Bits 0 to 4 flag attention button, power controller, latch, indicators.
// - Without slot implemented, optional fields are read-only and read zero.
// - Bit 5 flags that a slot device may be removed without notice.
// - Bit 6 flags that the slot supports hot insertion and removal.
// - Bits 14:7 hold the eight-bit slot power limit value.
// - Every slot capabilities register write requests a power limit message with value and scale; writes made while one is pending share one message.
// - Link going from down to data-link up also sends that message.
// - Bit 17 flags an electromechanical interlock on the chassis.
// - Bit 18 is zero and unwritable; command completion always notifies.
// - Bits 31:19 hold the physical slot number of the port.
`timescale 1ns/1ps
module psc_slot_cap
  import psc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dl_up,
  input wire logic init_load,
  input wire logic [31:0] init_value,
  input wire logic msg_ready,
  output logic msg_valid,
  output logic [7:0] msg_value,
  output logic [1:0] msg_scale,
  output logic [31:0] slot_capabilities
);
  typedef struct packed {
    logic [31:0] cap;
    logic unlock;
    logic slot;
    logic link_q;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [31:0] cap_out;
    logic trig;
  } psc_state_t;

  psc_state_t r;
  psc_state_t next_r;
  logic tx_busy;
  logic tx_valid;
  logic [7:0] tx_value;
  logic [1:0] tx_scale;

  // Merges write data into a word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Applies the field rules to a candidate capabilities word.
  function automatic logic [31:0] visible(input logic [31:0] v, input logic slot);
    logic [31:0] res;
    res = v;
    res[PSC_NO_CMD_DONE_BIT] = 1'b0;
    if (!slot) begin
      res = 32'h0000_0000;
    end
    return res;
  endfunction

  // Builds a new candidate word: lockable fields only when unlocked.
  function automatic logic [31:0] apply_write(input logic [31:0] old, input logic [31:0] nw,
                                              input logic unlocked);
    logic [31:0] res;
    res = old;
    res[PSC_LIMIT_MSB:PSC_LIMIT_LSB] = nw[PSC_LIMIT_MSB:PSC_LIMIT_LSB];
    res[PSC_SCALE_MSB:PSC_SCALE_LSB] = nw[PSC_SCALE_MSB:PSC_SCALE_LSB];
    if (unlocked) begin
      res[PSC_HOTPLUG_BIT:PSC_ATTN_BTN_BIT] = nw[PSC_HOTPLUG_BIT:PSC_ATTN_BTN_BIT];
      res[PSC_INTERLOCK_BIT] = nw[PSC_INTERLOCK_BIT];
      res[PSC_SLOTNUM_MSB:PSC_SLOTNUM_LSB] = nw[PSC_SLOTNUM_MSB:PSC_SLOTNUM_LSB];
    end
    return res;
  endfunction

  // Register file, APB slave and message trigger.
  always_comb begin
    logic access;
    logic [31:0] wv;
    access = psel && penable && !r.ready;
    wv = 32'h0000_0000;
    next_r = r;
    next_r.ready = 1'b0;
    next_r.err = 1'b0;
    next_r.trig = 1'b0;
    next_r.link_q = dl_up;
    if (init_load) begin
      next_r.cap = visible(apply_write(r.cap, init_value, 1'b1), r.slot);
    end
    if (access) begin
      next_r.ready = 1'b1;
      if (paddr == PSC_SLOT_CAP_ADDR) begin
        if (pwrite) begin
          wv = merge(r.cap, pwdata, pstrb);
          next_r.cap = visible(apply_write(next_r.cap, wv, r.unlock), r.slot);
          next_r.trig = 1'b1;
        end else begin
          next_r.rdata = r.cap_out;
        end
      end else if (paddr == PSC_CTRL_ADDR) begin
        if (pwrite) begin
          if (pstrb[0]) begin
            next_r.unlock = pwdata[PSC_CTRL_UNLOCK_BIT];
            next_r.slot = pwdata[PSC_CTRL_SLOT_BIT];
          end
        end else begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[PSC_CTRL_UNLOCK_BIT] = r.unlock;
          next_r.rdata[PSC_CTRL_SLOT_BIT] = r.slot;
          next_r.rdata[PSC_CTRL_BUSY_BIT] = tx_busy;
          next_r.rdata[PSC_CTRL_LINK_BIT] = r.link_q;
        end
      end else begin
        next_r.err = 1'b1;
        next_r.rdata = 32'h0000_0000;
      end
    end
    if (dl_up && !r.link_q) begin
      next_r.trig = 1'b1;
    end
    // Clearing the slot flag zeroes the stored optional fields too.
    next_r.cap = visible(next_r.cap, next_r.slot);
    next_r.cap_out = next_r.cap;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.cap <= PSC_SLOT_CAP_RESET;
      r.unlock <= PSC_UNLOCK_RESET;
      r.slot <= PSC_SLOT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Message sender takes the committed limit value and scale.
  psc_msg_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .req(r.trig),
    .value(r.cap[PSC_LIMIT_MSB:PSC_LIMIT_LSB]),
    .scale(r.cap[PSC_SCALE_MSB:PSC_SCALE_LSB]),
    .msg_ready(msg_ready),
    .msg_valid(tx_valid),
    .msg_value(tx_value),
    .msg_scale(tx_scale),
    .busy(tx_busy)
  );

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.err;
  assign slot_capabilities = r.cap_out;
  assign msg_valid = tx_valid;
  assign msg_value = tx_value;
  assign msg_scale = tx_scale;
endmodule

// ---- dv/psc_slot_cap_sva.sv ----
/* Checker for the slot capabilities block.
   Bound to psc_slot_cap and sees only its ports. */
`timescale 1ns/1ps
module psc_slot_cap_sva
  import psc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dl_up,
  input wire logic init_load,
  input wire logic msg_ready,
  input wire logic msg_valid,
  input wire logic [7:0] msg_value,
  input wire logic [1:0] msg_scale,
  input wire logic [31:0] slot_capabilities
);
  // All checks run on pclk and rest during reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && !pready;
  wire wr = psel && penable && pwrite;
  a_fixed_zero: assert property (slot_capabilities[18] == 1'b0) else $error("bit 18 set");
  a_ready_time: assert property (acc |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_map: assert property (pready && paddr != PSC_SLOT_CAP_ADDR && paddr != PSC_CTRL_ADDR
    |-> pslverr) else $error("no error");
  a_write_msg: assert property (wr && pready && paddr == PSC_SLOT_CAP_ADDR
    |-> ##[1:3] msg_valid) else $error("no write message");
  a_link_msg: assert property ($rose(dl_up) |-> ##[1:3] msg_valid) else $error("no link message");
  a_msg_hold: assert property (msg_valid && !msg_ready
    |=> msg_valid && $stable({msg_value, msg_scale})) else $error("message dropped");
  a_cap_stable: assert property (!wr && !init_load
    |=> $stable(slot_capabilities)) else $error("register moved");
  cover property (msg_valid && !msg_ready ##1 msg_ready);
  cover property ($rose(dl_up));
  cover property (pready && pslverr);
endmodule
bind psc_slot_cap psc_slot_cap_sva i_psc_slot_cap_sva(.*);

// ---- dv/psc_msg_sink.sv ----
/* Message path model taking the power limit messages.
   Shares pclk and presetn; slow stalls each message three cycles. */
`timescale 1ns/1ps
module psc_msg_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic msg_valid,
  input wire logic [7:0] msg_value,
  input wire logic [1:0] msg_scale,
  output logic msg_ready,
  output int n_msg,
  output logic [9:0] last
);
  int cnt;
  // Counts accepted messages and keeps the last value and scale.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_ready <= 1'b0;
      cnt <= 0;
      n_msg <= 0;
      last <= 10'h000;
    end else begin
      msg_ready <= 1'b0;
      if (msg_valid && msg_ready) begin
        n_msg <= n_msg + 1;
        last <= {msg_value, msg_scale};
        cnt <= 0;
      end else if (msg_valid) begin
        cnt <= cnt + 1;
        msg_ready <= cnt >= (slow ? 3 : 0);
      end
    end
  end
endmodule

// ---- dv/tb_top.sv ----
/* Bench for the slot capabilities block.
   Drives APB, init and link inputs; a message path model answers. */
`timescale 1ns/1ps
module tb_top;
  import psc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, dl_up, init_load, slow, er;
  logic pready, pslverr, msg_ready, msg_valid;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, init_value, slot_capabilities, rd, v;
  logic [7:0] msg_value;
  logic [1:0] msg_scale;
  logic [9:0] last;
  int n_fail, compares, n_msg, cyc;
  psc_slot_cap i_psc_slot_cap(.*);
  psc_msg_sink i_psc_msg_sink(.*);
  // Clock at 100 MHz and a hang limit.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // One APB transfer, held until pready; only the bench timeout ends the wait.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Waits for one more message and compares its value and scale.
  task automatic wmsg(input logic [9:0] e);
    int k;
    k = n_msg;
    repeat (30) if (n_msg == k) @(posedge pclk);
    chk("msg count", k + 1, n_msg);
    chk("msg", {22'h0, e}, {22'h0, last});
  endtask
  task automatic rdcap(input logic [31:0] e);
    apb(1'b0, PSC_SLOT_CAP_ADDR, 32'h0);
    chk("cap", e, rd);
  endtask
  // Reset value, unmapped address, and writes without a slot.
  task automatic t_reset();
    rdcap(PSC_SLOT_CAP_RESET);
    apb(1'b1, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, PSC_SLOT_CAP_ADDR, 32'hFFFFFFFF);
    wmsg(10'h000);
    rdcap(32'h0);
  endtask
  // Every scale with its own field values, unlocked, then locked.
  task automatic t_fields();
    apb(1'b1, PSC_CTRL_ADDR, 32'h3);
    for (int s = 0; s < 4; s++) begin
      v = {13'h1555 - 13'(s), 2'h3, 2'(s), 8'hA5 + 8'(s), 7'h55 + 7'(s)};
      apb(1'b1, PSC_SLOT_CAP_ADDR, v);
      wmsg({v[14:7], v[16:15]});
      rdcap(v & 32'hFFFBFFFF);
    end
    apb(1'b1, PSC_CTRL_ADDR, 32'h2);
    apb(1'b1, PSC_SLOT_CAP_ADDR, 32'h0);
    wmsg(10'h000);
    rdcap(v & 32'hFFFA007F);
    // A byte-strobed write while locked moves only limit and scale bits.
    pstrb <= 4'h2;
    apb(1'b1, PSC_SLOT_CAP_ADDR, 32'hFFFFFFFF);
    pstrb <= 4'hF;
    wmsg({8'hFE, 2'h1});
    rdcap((v & 32'hFFFA007F) | 32'h0000FF00);
  endtask
  // Init load passes the lock; link up sends a slowly taken message.
  task automatic t_init_link();
    init_value <= 32'h00023456; // On-board slot, so slot number zero.
    init_load <= 1'b1;
    @(posedge pclk);
    init_load <= 1'b0;
    @(posedge pclk);
    chk("init", 32'h00023456, slot_capabilities);
    slow <= 1'b1;
    dl_up <= 1'b1;
    wmsg({8'h68, 2'h0});
    apb(1'b0, PSC_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0000000A, rd);
    apb(1'b1, PSC_CTRL_ADDR, 32'h0);
    rdcap(32'h0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, dl_up, init_load, slow} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    init_value = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fields();
    t_init_link();
    test_done();
  end
endmodule
